// File: sdram_cke_pkg.sv
// shared constants and types for the clock-enable power state logic
package sdram_cke_pkg;
    localparam int ADDR_W        = 12;
    localparam int BANK_BIT      = 11;
    localparam int AP_BIT        = 10;
    localparam int BL_LSB        = 0;
    localparam int BL_W          = 3;
    localparam logic [2:0] BL_FULL_PAGE = 3'h7;
    localparam logic [11:0] MODE_RESET  = 12'h0000;
    localparam int CLK_MHZ       = 50;
    localparam int TRC_NS        = 70;
    localparam int TRC_CYC       = (TRC_NS * CLK_MHZ + 999) / 1000;
    localparam int TRRD_NS       = 20;
    localparam int TRRD_CYC      = (TRRD_NS * CLK_MHZ + 999) / 1000;
    localparam int TRAS_NS       = 42;
    localparam int TRAS_CYC      = (TRAS_NS * CLK_MHZ + 999) / 1000;
    localparam int TRCD_NS       = 20;
    localparam int TRCD_CYC      = (TRCD_NS * CLK_MHZ + 999) / 1000;
    localparam int BURST_CYC     = 4;
    localparam int CNT_W         = 8;

    typedef enum logic [3:0] {
        CMD_DESELECT = 4'h0, CMD_NOP = 4'h1, CMD_BURST_HALT = 4'h2, CMD_READ = 4'h3,
        CMD_WRITE = 4'h4, CMD_ACTIVATE = 4'h5, CMD_PRECHARGE = 4'h6,
        CMD_REFRESH = 4'h7, CMD_MODE_LOAD = 4'h8
    } cmd_e;

    typedef enum logic [2:0] {
        PS_IDLE = 3'b000, PS_ACTIVE = 3'b001, PS_POWER_DOWN = 3'b010,
        PS_SELF_REFRESH = 3'b011, PS_SR_RECOVERY = 3'b100, PS_AUTO_REFRESH = 3'b101
    } pwr_state_e;

    typedef enum logic [1:0] {
        BK_IDLE = 2'b00, BK_ACTIVE = 2'b01, BK_BURST = 2'b10
    } bank_state_e;

    function automatic cmd_e decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        logic [2:0] c;
        c = {ras_n, cas_n, we_n};
        if (cs_n)
            return CMD_DESELECT;
        case (c)
            3'b111:  return CMD_NOP;
            3'b110:  return CMD_BURST_HALT;
            3'b101:  return CMD_READ;
            3'b100:  return CMD_WRITE;
            3'b011:  return CMD_ACTIVATE;
            3'b010:  return CMD_PRECHARGE;
            3'b001:  return CMD_REFRESH;
            default: return CMD_MODE_LOAD;
        endcase
    endfunction : decode_cmd

    function automatic logic is_idle_cmd(input cmd_e c);
        return (c == CMD_DESELECT) || (c == CMD_NOP);
    endfunction : is_idle_cmd
endpackage : sdram_cke_pkg

// File: sdram_cmd_if.sv
// command and clock-enable pins between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface sdram_cmd_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [11:0] addr;

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr);
    modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, addr);
endinterface : sdram_cmd_if
`default_nettype wire

// File: sdram_bank_track.sv
// per-bank state tracker with timing counters
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_track (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // control
    input  wire logic                     advance,
    input  wire logic                     do_activate,
    input  wire logic                     do_column,
    input  wire logic                     column_ap,
    input  wire logic                     do_precharge,
    input  wire logic                     do_halt,
    // state
    output var sdram_cke_pkg::bank_state_e state,
    output logic                          auto_pre,
    output logic                          rcd_met,
    output logic                          ras_met
);
    logic [sdram_cke_pkg::CNT_W-1:0] since_act;
    logic [sdram_cke_pkg::CNT_W-1:0] burst_left;

    always_ff @(posedge clk) begin
        if (rst) begin
            since_act <= '0;
        end else if (do_activate) begin
            since_act <= '0;
        end else if (advance && since_act != '1) begin
            since_act <= since_act + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= sdram_cke_pkg::BK_IDLE;
            auto_pre   <= 1'b0;
            burst_left <= '0;
        end else if (do_activate) begin
            state <= sdram_cke_pkg::BK_ACTIVE;
        end else if (do_precharge) begin
            state    <= sdram_cke_pkg::BK_IDLE;
            auto_pre <= 1'b0;
        end else if (do_column) begin
            state      <= sdram_cke_pkg::BK_BURST;
            auto_pre   <= column_ap;
            burst_left <= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::BURST_CYC - 1);
        end else if (do_halt && state == sdram_cke_pkg::BK_BURST) begin
            state <= sdram_cke_pkg::BK_ACTIVE;
        end else if (advance && state == sdram_cke_pkg::BK_BURST) begin
            if (burst_left == '0) begin
                state    <= auto_pre ? sdram_cke_pkg::BK_IDLE : sdram_cke_pkg::BK_ACTIVE;
                auto_pre <= 1'b0;
            end else begin
                burst_left <= burst_left - 1'b1;
            end
        end
    end

    assign rcd_met = since_act >= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::TRCD_CYC);
    assign ras_met = since_act >= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::TRAS_CYC);
endmodule : sdram_bank_track
`default_nettype wire

// File: sdram_mem_end.sv
// memory end: command qualification and clock-enable power states
// What this block does
// - sample inputs on rising clock edge only
// - mode load captures A0..A11 as operating code
// - controller idles both banks before mode/refresh
// - refresh uses internal row, ignores pins
// - self-refresh ignores all but clock enable
// - activate idle bank; column to active bank
// - burst halt valid only at full page
// - bank legality follows bank selected by A11
// - idle, CKE falls, nop: enter power-down
// - idle, CKE falls, refresh code: self-refresh
// - second activate waits bank-to-bank interval
// - no precharge before row-active time
// - auto-precharge idles bank after burst
// - column command waits activate-to-column delay
// - CKE rise nop exits self-refresh; tRC idle
// - recovery CKE drop with nop: power-down
// - power-down exits on CKE low-to-high
// - active state with a bank open: CKE low suspends clock
// - idle decode: activate/precharge, refresh, mode load
// - CKE rise reactivates inputs from the next cycle
`timescale 1ns/1ps
`default_nettype none
module sdram_mem_end (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // command pins
    sdram_cmd_if.mem                   pins,
    // status
    output logic [11:0]                operating_code,
    output var sdram_cke_pkg::pwr_state_e power_state,
    output logic                       suspended,
    output logic [1:0]                 bank_busy,
    output logic                       illegal_cmd,
    output logic                       refresh_event
);
    // synchronised pins
    logic        cke_m, cke_s, cke_prev;
    logic [3:0]  ctl_m, ctl_s;
    logic [11:0] addr_m, addr_s;
    sdram_cke_pkg::cmd_e          cmd;
    sdram_cke_pkg::bank_state_e   burst_halt_cmd [2];
    logic [1:0]  rcd_ok, ras_ok;
    logic        both_idle, bank_sel, run, halt_ok, legal;
    logic [1:0]  act_go, col_go, pre_go, halt_go;
    logic [sdram_cke_pkg::CNT_W-1:0] rc_cnt, rrd_cnt;

    always_ff @(posedge clk) begin
        cke_m  <= pins.cke;
        cke_s  <= cke_m;
        ctl_m  <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
        ctl_s  <= ctl_m;
        addr_m <= pins.addr;
        addr_s <= addr_m;
    end

    always_ff @(posedge clk) begin
        if (rst)
            cke_prev <= 1'b1;
        else
            cke_prev <= cke_s;
    end

    assign cmd       = sdram_cke_pkg::decode_cmd(ctl_s[3], ctl_s[2], ctl_s[1], ctl_s[0]);
    assign both_idle = burst_halt_cmd[0] == sdram_cke_pkg::BK_IDLE && burst_halt_cmd[1] == sdram_cke_pkg::BK_IDLE;
    assign bank_sel  = addr_s[sdram_cke_pkg::BANK_BIT];
    // commands act only with CKE high on both edges and no suspension
    assign run       = cke_prev && cke_s && !suspended;
    assign halt_ok   = operating_code[sdram_cke_pkg::BL_LSB +: sdram_cke_pkg::BL_W]
                       == sdram_cke_pkg::BL_FULL_PAGE;

    // per-bank legality
    always_comb begin
        act_go  = '0;
        col_go  = '0;
        pre_go  = '0;
        halt_go = '0;
        legal   = 1'b1;
        if (run && (power_state == sdram_cke_pkg::PS_IDLE
                    || power_state == sdram_cke_pkg::PS_ACTIVE)) begin
            case (cmd)
                sdram_cke_pkg::CMD_ACTIVATE: begin
                    legal = burst_halt_cmd[bank_sel] == sdram_cke_pkg::BK_IDLE
                            && (both_idle || rrd_cnt == '0);
                    act_go[bank_sel] = legal;
                end
                sdram_cke_pkg::CMD_READ, sdram_cke_pkg::CMD_WRITE: begin
                    legal = burst_halt_cmd[bank_sel] != sdram_cke_pkg::BK_IDLE
                            && rcd_ok[bank_sel];
                    col_go[bank_sel] = legal;
                end
                sdram_cke_pkg::CMD_PRECHARGE: begin
                    if (addr_s[sdram_cke_pkg::AP_BIT]) begin
                        legal  = (burst_halt_cmd[0] == sdram_cke_pkg::BK_IDLE || ras_ok[0])
                                 && (burst_halt_cmd[1] == sdram_cke_pkg::BK_IDLE || ras_ok[1]);
                        pre_go = {2{legal}};
                    end else begin
                        legal = burst_halt_cmd[bank_sel] == sdram_cke_pkg::BK_IDLE
                                || ras_ok[bank_sel];
                        pre_go[bank_sel] = legal;
                    end
                end
                sdram_cke_pkg::CMD_BURST_HALT: begin
                    legal   = halt_ok;
                    halt_go = {2{halt_ok}};
                end
                sdram_cke_pkg::CMD_REFRESH, sdram_cke_pkg::CMD_MODE_LOAD: begin
                    legal = both_idle;
                end
                default: legal = 1'b1;
            endcase
        end else if (!cmd_idle_ok() && cke_prev
                     && power_state == sdram_cke_pkg::PS_SR_RECOVERY) begin
            legal = 1'b0;
        end else if (!cmd_idle_ok() && !cke_prev && cke_s
                     && power_state == sdram_cke_pkg::PS_SELF_REFRESH) begin
            legal = 1'b0;
        end
    end

    // deselect, or ras and cas high: tolerated around self-refresh exit
    function automatic logic cmd_idle_ok();
        return ctl_s[3] || (ctl_s[2] && ctl_s[1]);
    endfunction : cmd_idle_ok

    for (genvar b = 0; b < 2; b++) begin : g_bank
        sdram_bank_track u_bank (
            .clk          (clk),
            .rst          (rst),
            .advance      (run),
            .do_activate  (act_go[b]),
            .do_column    (col_go[b]),
            .column_ap    (addr_s[sdram_cke_pkg::AP_BIT]),
            .do_precharge (pre_go[b]),
            .do_halt      (halt_go[b]),
            .state        (burst_halt_cmd[b]),
            .auto_pre     (),
            .rcd_met      (rcd_ok[b]),
            .ras_met      (ras_ok[b])
        );
    end

    // bank-to-bank activate spacing
    always_ff @(posedge clk) begin
        if (rst)
            rrd_cnt <= '0;
        else if (|act_go)
            rrd_cnt <= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::TRRD_CYC - 1);
        else if (rrd_cnt != '0)
            rrd_cnt <= rrd_cnt - 1'b1;
    end

    // power state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            power_state   <= sdram_cke_pkg::PS_IDLE;
            rc_cnt        <= '0;
            refresh_event <= 1'b0;
        end else begin
            refresh_event <= 1'b0;
            case (power_state)
                sdram_cke_pkg::PS_IDLE, sdram_cke_pkg::PS_ACTIVE: begin
                    if (both_idle && cke_prev && !cke_s) begin
                        if (ctl_s == 4'b0001)
                            power_state <= sdram_cke_pkg::PS_SELF_REFRESH;
                        else if (sdram_cke_pkg::is_idle_cmd(cmd))
                            power_state <= sdram_cke_pkg::PS_POWER_DOWN;
                    end else if (run && both_idle && cmd == sdram_cke_pkg::CMD_REFRESH) begin
                        power_state   <= sdram_cke_pkg::PS_AUTO_REFRESH;
                        refresh_event <= 1'b1;
                        rc_cnt        <= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::TRC_CYC - 1);
                    end else begin
                        power_state <= (both_idle && !(|act_go)) ? sdram_cke_pkg::PS_IDLE
                                                                 : sdram_cke_pkg::PS_ACTIVE;
                    end
                end
                sdram_cke_pkg::PS_AUTO_REFRESH: begin
                    if (rc_cnt == '0)
                        power_state <= sdram_cke_pkg::PS_IDLE;
                    else
                        rc_cnt <= rc_cnt - 1'b1;
                end
                sdram_cke_pkg::PS_SELF_REFRESH: begin
                    if (!cke_prev && cke_s) begin
                        power_state <= sdram_cke_pkg::PS_SR_RECOVERY;
                        rc_cnt      <= sdram_cke_pkg::CNT_W'(sdram_cke_pkg::TRC_CYC - 1);
                    end
                end
                sdram_cke_pkg::PS_SR_RECOVERY: begin
                    if (cke_prev && !cke_s && cmd_idle_ok())
                        power_state <= sdram_cke_pkg::PS_POWER_DOWN;
                    else if (cke_prev && cke_s && cmd_idle_ok()) begin
                        if (rc_cnt == '0)
                            power_state <= sdram_cke_pkg::PS_IDLE;
                        else
                            rc_cnt <= rc_cnt - 1'b1;
                    end
                end
                sdram_cke_pkg::PS_POWER_DOWN: begin
                    if (!cke_prev && cke_s)
                        power_state <= sdram_cke_pkg::PS_IDLE;
                end
                default: power_state <= sdram_cke_pkg::PS_IDLE;
            endcase
        end
    end

    // clock suspend outside both-idle
    always_ff @(posedge clk) begin
        if (rst)
            suspended <= 1'b0;
        else if (power_state == sdram_cke_pkg::PS_ACTIVE && !both_idle)
            suspended <= !cke_s;
        else
            suspended <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst)
            operating_code <= sdram_cke_pkg::MODE_RESET;
        else if (run && both_idle && power_state == sdram_cke_pkg::PS_IDLE
                 && cmd == sdram_cke_pkg::CMD_MODE_LOAD)
            operating_code <= addr_s;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_cmd <= 1'b0;
            bank_busy   <= '0;
        end else begin
            illegal_cmd <= !legal;
            bank_busy   <= {burst_halt_cmd[1] != sdram_cke_pkg::BK_IDLE, burst_halt_cmd[0] != sdram_cke_pkg::BK_IDLE};
        end
    end
endmodule : sdram_mem_end
`default_nettype wire

// File: sdram_ctrl_end.sv
// controller end: drives command pins and clock enable from user requests
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_end (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // user request
    input  wire logic         req_valid,
    input  wire logic [3:0]   req_cmd,
    input  wire logic [11:0]  req_addr,
    input  wire logic         req_cke,
    output logic              req_ready,
    // pins
    sdram_cmd_if.ctrl         pins
);
    logic [sdram_cke_pkg::CNT_W-1:0] gap;

    // one command per slot, then a rest of one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pins.cke   <= 1'b1;
            pins.cs_n  <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n  <= 1'b1;
            pins.addr  <= '0;
            req_ready  <= 1'b0;
            gap        <= '0;
        end else begin
            pins.cke <= req_cke;
            if (req_valid && req_ready) begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd;
                pins.addr <= req_addr;
                req_ready <= 1'b0;
                gap       <= sdram_cke_pkg::CNT_W'(1);
            end else begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
                if (gap != '0)
                    gap <= gap - 1'b1;
                req_ready <= (gap == '0) || (gap == sdram_cke_pkg::CNT_W'(1));
            end
        end
    end
endmodule : sdram_ctrl_end
`default_nettype wire

// File: sdram_cke_power_state_control_assertions.sv
// concurrent checks on the command pins and the memory-end status
`timescale 1ns/1ps
`default_nettype none
module sdram_cke_power_state_control_assertions (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // interface pins
    input  wire logic                         cke,
    input  wire logic                         cs_n,
    input  wire logic                         ras_n,
    input  wire logic                         cas_n,
    input  wire logic                         we_n,
    input  wire logic [11:0]                  addr,
    // memory-end status
    input  wire logic [11:0]                  operating_code,
    input  var  sdram_cke_pkg::pwr_state_e    power_state,
    input  wire logic                         suspended,
    input  wire logic                         illegal_cmd,
    input  wire logic                         refresh_event
);
    localparam int LAG     = 6;
    localparam int REC_MAX = sdram_cke_pkg::TRC_CYC + 6;
    logic        cke_prev;
    logic [7:0]  since_ml;
    logic [7:0]  since_ref;
    logic [7:0]  since_sr;
    logic [7:0]  since_fall;
    logic [7:0]  since_rise;
    logic [7:0]  low_cnt;
    logic [7:0]  rec_cnt;
    logic [11:0] ml_addr;
    wire  logic  ctl_ref = !cs_n && !ras_n && !cas_n && we_n;
    wire  logic  ctl_ml  = !cs_n && !ras_n && !cas_n && !we_n;

    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction : inc

    // cycles since each cause was seen on the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            cke_prev   <= 1'b1;
            since_ml   <= 8'hff;
            since_ref  <= 8'hff;
            since_sr   <= 8'hff;
            since_fall <= 8'hff;
            since_rise <= 8'hff;
            ml_addr    <= 12'h000;
        end else begin
            cke_prev   <= cke;
            since_ml   <= (ctl_ml && cke && cke_prev) ? 8'h00 : inc(since_ml);
            since_ref  <= (ctl_ref && cke && cke_prev) ? 8'h00 : inc(since_ref);
            since_sr   <= (ctl_ref && !cke && cke_prev) ? 8'h00 : inc(since_sr);
            since_fall <= (!cke && cke_prev) ? 8'h00 : inc(since_fall);
            since_rise <= (cke && !cke_prev) ? 8'h00 : inc(since_rise);
            if (ctl_ml && cke && cke_prev)
                ml_addr <= addr;
        end
    end

    // run lengths of low clock enable and of recovery
    always_ff @(posedge clk) begin
        if (rst) begin
            low_cnt <= 8'h00;
            rec_cnt <= 8'h00;
        end else begin
            low_cnt <= cke ? 8'h00 : inc(low_cnt);
            rec_cnt <= (power_state == sdram_cke_pkg::PS_SR_RECOVERY) ? inc(rec_cnt) : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_code_needs_load: assert property (operating_code != $past(operating_code) |-> since_ml <= LAG)
        else $error("operating code changed without a recent mode load");
    a_code_takes_addr: assert property (operating_code != $past(operating_code) |-> operating_code == ml_addr)
        else $error("operating code differs from mode load address");
    a_refresh_cause: assert property (refresh_event |-> since_ref <= LAG && !$past(refresh_event))
        else $error("refresh event without a recent refresh command");
    a_pd_entry: assert property ((power_state == sdram_cke_pkg::PS_POWER_DOWN
        && $past(power_state) != sdram_cke_pkg::PS_POWER_DOWN) |-> since_fall <= LAG)
        else $error("power-down entered without clock enable falling");
    a_sr_entry: assert property ((power_state == sdram_cke_pkg::PS_SELF_REFRESH
        && $past(power_state) != sdram_cke_pkg::PS_SELF_REFRESH) |-> since_sr <= LAG)
        else $error("self-refresh entered without refresh code and falling enable");
    a_sr_ignores: assert property ((power_state == sdram_cke_pkg::PS_SELF_REFRESH && low_cnt >= LAG)
        |=> power_state == sdram_cke_pkg::PS_SELF_REFRESH && !refresh_event && !illegal_cmd)
        else $error("self-refresh reacted to pins other than clock enable");
    a_pd_exit: assert property (($past(power_state) == sdram_cke_pkg::PS_POWER_DOWN
        && power_state != sdram_cke_pkg::PS_POWER_DOWN) |-> since_rise <= LAG)
        else $error("power-down left without clock enable rising");
    a_pd_hold: assert property ((power_state == sdram_cke_pkg::PS_POWER_DOWN && low_cnt >= LAG)
        |=> power_state == sdram_cke_pkg::PS_POWER_DOWN)
        else $error("power-down left while clock enable low");
    a_suspend_on: assert property ($rose(suspended) |-> since_fall <= LAG)
        else $error("suspend began without clock enable falling");
    a_suspend_off: assert property ($fell(suspended) |-> since_rise <= LAG)
        else $error("suspend ended without clock enable rising");
    a_recovery_bound: assert property (rec_cnt <= REC_MAX)
        else $error("self-refresh recovery lasted too long");
    a_cmd_one_cycle: assert property ((!cs_n && !(ras_n && cas_n && we_n))
        |=> (cs_n || (ras_n && cas_n && we_n)))
        else $error("command held on pins beyond one cycle");
endmodule : sdram_cke_power_state_control_assertions
`default_nettype wire

// File: test_sdram_cke_power_state_control.sv
// self-checking bench for both ends joined by the command pins
`timescale 1ns/1ps
`default_nettype none
module test_sdram_cke_power_state_control;
    localparam logic [3:0] C_NOP = 4'h7;
    localparam logic [3:0] C_REF = 4'h1;
    localparam logic [3:0] C_ML  = 4'h0;
    localparam logic [3:0] C_ACT = 4'h3;
    localparam logic [3:0] C_PRE = 4'h2;
    localparam logic [3:0] C_RD  = 4'h5;
    localparam logic [3:0] EXITS [4] = '{4'hf, C_NOP, C_RD, C_ACT};
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      req_valid = 1'b0;
    logic [3:0]                req_cmd = 4'h7;
    logic [11:0]               req_addr = 12'h000;
    logic                      req_cke = 1'b1;
    logic                      req_ready;
    logic [11:0]               operating_code;
    sdram_cke_pkg::pwr_state_e power_state;
    logic                      suspended;
    logic [1:0]                bank_busy;
    logic                      illegal_cmd;
    logic                      refresh_event;
    logic [11:0]               code;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 39754;
    int n_illegal = 0;
    int n_refresh = 0;
    int ni;
    int i;

    sdram_cmd_if pins_if ();
    sdram_ctrl_end u_sdram_ctrl_end (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_addr(req_addr), .req_cke(req_cke), .req_ready(req_ready),
        .pins(pins_if.ctrl));
    sdram_mem_end u_sdram_mem_end (.clk(clk), .rst(rst), .pins(pins_if.mem),
        .operating_code(operating_code), .power_state(power_state), .suspended(suspended),
        .bank_busy(bank_busy), .illegal_cmd(illegal_cmd), .refresh_event(refresh_event));
    sdram_cke_power_state_control_assertions u_checks (.clk(clk), .rst(rst),
        .cke(pins_if.cke), .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n),
        .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .addr(pins_if.addr),
        .operating_code(operating_code), .power_state(power_state), .suspended(suspended),
        .illegal_cmd(illegal_cmd), .refresh_event(refresh_event));

    always #10 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (illegal_cmd === 1'b1) n_illegal++;
        if (refresh_event === 1'b1) n_refresh++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one request at a falling edge, held until taken, then settle
    task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic k, input int n);
        int t;
        t = 0;
        while (req_ready !== 1'b1 && t < 50) begin
            @(negedge clk);
            t++;
        end
        if (t == 50) failures++;
        req_valid = 1'b1;
        req_cmd   = c;
        req_addr  = a;
        req_cke   = k;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask : issue

    task automatic wait_state(input sdram_cke_pkg::pwr_state_e st);
        int t;
        t = 0;
        while (power_state !== st && t < 40) begin
            @(negedge clk);
            t++;
        end
        check("power state", 12'(st), 12'(power_state));
    endtask : wait_state

    // exit from self-refresh is clean only with deselect, nop or burst halt
    function automatic logic exit_bad(input logic [3:0] c);
        return !(c[3] || (c[2] && c[1]));
    endfunction : exit_bad

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check("reset code", 12'h000, operating_code);
        wait_state(sdram_cke_pkg::PS_IDLE);
        check("reset cke", 12'h001, {11'h000, pins_if.cke});
        for (i = 0; i < 6; i++) begin
            code = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($random(seed));
            issue(C_ML, code, 1'b1, 8);
            check("operating code", code, operating_code);
        end
        ni = n_refresh;
        issue(C_REF, 12'($random(seed)), 1'b1, 8);
        check("refresh count", 12'(ni + 1), 12'(n_refresh));
        check("code after refresh", code, operating_code);
        wait_state(sdram_cke_pkg::PS_IDLE);
        issue(C_NOP, 12'h000, 1'b0, 8);
        wait_state(sdram_cke_pkg::PS_POWER_DOWN);
        issue(C_ML, ~code, 1'b0, 8);
        check("code in power-down", code, operating_code);
        issue(C_NOP, 12'h000, 1'b1, 8);
        wait_state(sdram_cke_pkg::PS_IDLE);
        for (i = 0; i < 4; i++) begin
            issue(C_REF, 12'h000, 1'b0, 8);
            wait_state(sdram_cke_pkg::PS_SELF_REFRESH);
            issue(C_ML, ~code, 1'b0, 8);
            check("code in self-refresh", code, operating_code);
            ni = n_illegal;
            issue(EXITS[i], 12'h000, 1'b1, 8);
            check("exit illegal", 12'(ni + exit_bad(EXITS[i])), 12'(n_illegal));
            issue(C_NOP, 12'h000, 1'b0, 8);
            issue(C_NOP, 12'h000, 1'b1, 8);
            wait_state(sdram_cke_pkg::PS_IDLE);
        end
        issue(C_REF, 12'h000, 1'b0, 8);
        issue(C_NOP, 12'h000, 1'b1, 0);
        issue(C_NOP, 12'h000, 1'b0, 8);
        wait_state(sdram_cke_pkg::PS_POWER_DOWN);
        issue(C_NOP, 12'h000, 1'b1, 8);
        wait_state(sdram_cke_pkg::PS_IDLE);
        issue(C_ACT, 12'h000, 1'b1, 8);
        check("bank busy", 12'h001, {10'h000, bank_busy});
        ni = n_illegal;
        issue(C_RD, 12'h800, 1'b1, 8);
        check("read idle bank", 12'(ni + 1), 12'(n_illegal));
        issue(C_RD, 12'h000, 1'b1, 8);
        issue(C_ML, 12'h000, 1'b1, 8);
        check("active bank cmds", 12'(ni + 2), 12'(n_illegal));
        issue(4'h6, 12'h000, 1'b1, 8);
        check("burst halt", 12'(ni + 2 + int'(code[2:0] != 3'h7)), 12'(n_illegal));
        issue(C_NOP, 12'h000, 1'b0, 8);
        check("suspended", 12'h001, {11'h000, suspended});
        issue(C_NOP, 12'h000, 1'b1, 8);
        check("resumed", 12'h000, {11'h000, suspended});
        issue(C_PRE, 12'h400, 1'b1, 8);
        wait_state(sdram_cke_pkg::PS_IDLE);
        issue(C_ACT, 12'h800, 1'b1, 8);
        issue(C_RD, 12'hc00, 1'b1, 12);
        check("auto precharge", 12'h000, {10'h000, bank_busy});
        wrap_up();
    end
endmodule : test_sdram_cke_power_state_control
`default_nettype wire
